// [verilog/ccs_top.sv]
// CPU clock selector: control registers, oscillator gating and glitch-free source switch
module ccs_top
    import ccs_pkg::*;
#(
    parameter bit HAS_MULT_REG = 1'b1            // Variant carries the multiplier register
) (
    input  wire logic        REF_CLK_I,          // System clock, 100 MHz
    input  wire logic        RST_I,              // Synchronous reset, active high
    input  wire logic        PIN_RST_I,          // Reset from the reset pin, active high
    input  wire logic        STOP_I,             // STOP instruction executed, level
    input  wire logic [15:0] ADDR_I,             // Register address
    input  wire logic        WR_I,               // Write strobe
    input  wire logic [7:0]  WDATA_I,            // Write data
    input  wire logic        RD_I,               // Read strobe
    output logic      [7:0]  RDATA_O,            // Read data, registered
    output logic             MAIN_OSC_EN_O,      // Main oscillator enable
    output logic             SUB_OSC_EN_O,       // Subsystem oscillator enable
    output logic             FB_RES_EN_O,        // Feedback resistor connected
    output logic      [1:0]  CPU_SRC_O,          // Source now driving the CPU
    output logic             CPU_CLK_GATE_O      // CPU clock gate, low during switch gap
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic       main_osc_stop_reg,      main_osc_stop_next;
    logic       main_divide_select_reg, main_divide_select_next;
    logic       feedback_resistor_off_reg, feedback_resistor_off_next;
    logic       sub_osc_stop_reg,       sub_osc_stop_next;
    logic       osc_source_select_reg,  osc_source_select_next;
    logic       multiplier_enable_reg,  multiplier_enable_next;
    logic       mult_written_reg,       mult_written_next;
    logic [7:0] rdata_reg,              rdata_next;

    // Switch state
    ccs_state_t state_reg, state_next;
    logic [1:0] gap_cnt_reg,  gap_cnt_next;
    logic [1:0] cur_src_reg,  cur_src_next;
    logic       gate_reg,     gate_next;
    logic       main_en_reg,  main_en_next;
    logic       sub_en_reg,   sub_en_next;
    logic       fb_en_reg,    fb_en_next;

    logic       on_sub;
    logic [1:0] want_src;

    assign on_sub = cur_src_reg[1];
    // Requested source from the control bits
    assign want_src = osc_source_select_reg
                    ? (multiplier_enable_reg ? SRC_SUB_MULT : SRC_SUB)
                    : (main_divide_select_reg ? SRC_MAIN_DIV : SRC_MAIN);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Software writes and reads; reserved bits are dropped and read zero
    always_comb begin
        main_osc_stop_next         = main_osc_stop_reg;
        main_divide_select_next    = main_divide_select_reg;
        feedback_resistor_off_next = feedback_resistor_off_reg;
        sub_osc_stop_next          = sub_osc_stop_reg;
        osc_source_select_next     = osc_source_select_reg;
        multiplier_enable_next     = multiplier_enable_reg;
        mult_written_next          = mult_written_reg;
        rdata_next                 = rdata_reg;
        if (WR_I) begin
            unique case (ADDR_I)
                ADDR_PROC_CLK: begin
                    // Setting stop is refused while the main clock drives the CPU
                    if (!WDATA_I[BIT_MAIN_STOP] || on_sub) begin
                        main_osc_stop_next = WDATA_I[BIT_MAIN_STOP];
                    end
                    main_divide_select_next = WDATA_I[BIT_DIV_SEL];
                end
                ADDR_OSC_MODE: begin
                    feedback_resistor_off_next = WDATA_I[BIT_FB_OFF];
                    sub_osc_stop_next          = WDATA_I[BIT_SUB_STOP];
                end
                ADDR_SUB_CTRL: begin
                    osc_source_select_next = WDATA_I[BIT_SRC_SEL];
                end
                ADDR_MULT_SEL: begin
                    // First write wins; later ones are dropped until the pin reset
                    if (HAS_MULT_REG && !mult_written_reg) begin
                        multiplier_enable_next = WDATA_I[BIT_MULT_EN];
                        mult_written_next      = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (RD_I) begin
            rdata_next = 8'h00;
            unique case (ADDR_I)
                ADDR_PROC_CLK: begin
                    rdata_next[BIT_MAIN_STOP] = main_osc_stop_reg;
                    rdata_next[BIT_DIV_SEL]   = main_divide_select_reg;
                end
                ADDR_OSC_MODE: begin
                    rdata_next[BIT_FB_OFF]   = feedback_resistor_off_reg;
                    rdata_next[BIT_SUB_STOP] = sub_osc_stop_reg;
                end
                ADDR_SUB_CTRL: begin
                    rdata_next[BIT_CLK_STATUS] = on_sub;
                    rdata_next[BIT_SRC_SEL]    = osc_source_select_reg;
                end
                ADDR_MULT_SEL: begin
                    rdata_next[BIT_MULT_EN] = HAS_MULT_REG & multiplier_enable_reg;
                end
                default: begin
                end
            endcase
        end
    end

    // Ordinary resets load the control bits' reset values; the multiplier bit needs the pin
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            main_osc_stop_reg         <= RST_PROC_CLK[BIT_MAIN_STOP];
            main_divide_select_reg    <= RST_PROC_CLK[BIT_DIV_SEL];
            feedback_resistor_off_reg <= RST_OSC_MODE[BIT_FB_OFF];
            sub_osc_stop_reg          <= RST_OSC_MODE[BIT_SUB_STOP];
            osc_source_select_reg     <= RST_SUB_CTRL[BIT_SRC_SEL];
            rdata_reg                 <= 8'h00;
        end else begin
            main_osc_stop_reg         <= main_osc_stop_next;
            main_divide_select_reg    <= main_divide_select_next;
            feedback_resistor_off_reg <= feedback_resistor_off_next;
            sub_osc_stop_reg          <= sub_osc_stop_next;
            osc_source_select_reg     <= osc_source_select_next;
            rdata_reg                 <= rdata_next;
        end
        if (PIN_RST_I) begin
            multiplier_enable_reg <= RST_MULT_SEL[BIT_MULT_EN];
            mult_written_reg      <= 1'b0;
        end else begin
            multiplier_enable_reg <= multiplier_enable_next;
            mult_written_reg      <= mult_written_next;
        end
    end

    // ------------------------------------------------------------
    // Glitch-free switch and oscillator gating
    // ------------------------------------------------------------
    // Gate off, wait a short gap, then hand over: no runt pulse reaches the CPU
    always_comb begin
        state_next   = state_reg;
        gap_cnt_next = gap_cnt_reg;
        cur_src_next = cur_src_reg;
        gate_next    = gate_reg;
        unique case (state_reg)
            CCS_RUN: begin
                if (want_src != cur_src_reg) begin
                    state_next   = CCS_GAP;
                    gate_next    = 1'b0;
                    gap_cnt_next = SWITCH_GAP;
                end
            end
            CCS_GAP: begin
                if (gap_cnt_reg == 2'h1) begin
                    state_next = CCS_LOAD;
                end
                gap_cnt_next = gap_cnt_reg - 2'h1;
            end
            CCS_LOAD: begin
                // Status follows only once the new source is the one gated through
                cur_src_next = want_src;
                gate_next    = 1'b1;
                state_next   = CCS_RUN;
            end
            default: begin
                state_next = CCS_RUN;
            end
        endcase
        // The divided main clock is the default, so the main oscillator runs unless its stop bit is set or STOP_I is high
        main_en_next = !(main_osc_stop_reg || STOP_I);
        sub_en_next  = !sub_osc_stop_reg;
        fb_en_next   = !feedback_resistor_off_reg;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_reg   <= CCS_RUN;
            gap_cnt_reg <= 2'h0;
            cur_src_reg <= SRC_MAIN_DIV;
            gate_reg    <= 1'b1;
            main_en_reg <= 1'b1;
            sub_en_reg  <= 1'b1;
            fb_en_reg   <= 1'b1;
        end else begin
            state_reg   <= state_next;
            gap_cnt_reg <= gap_cnt_next;
            cur_src_reg <= cur_src_next;
            gate_reg    <= gate_next;
            main_en_reg <= main_en_next;
            sub_en_reg  <= sub_en_next;
            fb_en_reg   <= fb_en_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA_O        = rdata_reg;
    assign MAIN_OSC_EN_O  = main_en_reg;
    assign SUB_OSC_EN_O   = sub_en_reg;
    assign FB_RES_EN_O    = fb_en_reg;
    assign CPU_SRC_O      = cur_src_reg;
    assign CPU_CLK_GATE_O = gate_reg;

endmodule : ccs_top

// [inc/ccs_pkg.sv]
// Package: register map, field positions and reset values of the CPU clock selector
package ccs_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_MULT_SEL  = 16'hFF46;
    localparam logic [15:0] ADDR_OSC_MODE  = 16'hFFF0;
    localparam logic [15:0] ADDR_SUB_CTRL  = 16'hFFF2;
    localparam logic [15:0] ADDR_PROC_CLK  = 16'hFFFB;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_MAIN_STOP   = 7;
    localparam int BIT_DIV_SEL     = 1;
    localparam int BIT_FB_OFF      = 1;
    localparam int BIT_SUB_STOP    = 0;
    localparam int BIT_CLK_STATUS  = 5;
    localparam int BIT_SRC_SEL     = 4;
    localparam int BIT_MULT_EN     = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PROC_CLK = 8'h02;
    localparam logic [7:0] RST_OSC_MODE = 8'h00;
    localparam logic [7:0] RST_SUB_CTRL = 8'h00;
    localparam logic [7:0] RST_MULT_SEL = 8'h00;

    // Cycles the clock mux spends in CCS_GAP while switching; the output stays gated one more, in CCS_LOAD
    localparam logic [1:0] SWITCH_GAP   = 2'h2;

    // CPU clock source codes
    localparam logic [1:0] SRC_MAIN     = 2'h0;
    localparam logic [1:0] SRC_MAIN_DIV = 2'h1;
    localparam logic [1:0] SRC_SUB      = 2'h2;
    localparam logic [1:0] SRC_SUB_MULT = 2'h3;

    // Switch state machine
    typedef enum logic [2:0] {
        CCS_RUN  = 3'b001,
        CCS_GAP  = 3'b010,
        CCS_LOAD = 3'b100
    } ccs_state_t;

endpackage : ccs_pkg

// [bench/ccs_props.sv]
// Checker: port properties of the CPU clock selector
module ccs_props
    import ccs_pkg::*;
(
    input wire logic        REF_CLK_I,      // Clock
    input wire logic        RST_I,          // Reset, active high
    input wire logic        STOP_I,         // Stop level
    input wire logic [15:0] ADDR_I,         // Address
    input wire logic        WR_I,           // Write strobe
    input wire logic [7:0]  WDATA_I,        // Write data
    input wire logic        RD_I,           // Read strobe
    input wire logic [7:0]  RDATA_O,        // Read data
    input wire logic        MAIN_OSC_EN_O,  // Main enable
    input wire logic        SUB_OSC_EN_O,   // Sub enable
    input wire logic        FB_RES_EN_O,    // Resistor connected
    input wire logic [1:0]  CPU_SRC_O,      // Source driving CPU
    input wire logic        CPU_CLK_GATE_O  // Clock gate
);
    // ------------------------------------------------------------
    // Decoded accesses and properties
    // ------------------------------------------------------------
    wire logic wr_proc = WR_I && ADDR_I == ADDR_PROC_CLK;
    wire logic wr_mode = WR_I && ADDR_I == ADDR_OSC_MODE;
    wire logic wr_sub  = WR_I && ADDR_I == ADDR_SUB_CTRL;
    wire logic rd_sub  = RD_I && ADDR_I == ADDR_SUB_CTRL;
    default clocking @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    a_reset_values: assert property ($fell(RST_I) |-> RDATA_O == 8'h00 && MAIN_OSC_EN_O && SUB_OSC_EN_O
        && FB_RES_EN_O && CPU_SRC_O == SRC_MAIN_DIV && CPU_CLK_GATE_O) else $error("reset state wrong");
    a_stop_main: assert property (STOP_I [*3] |-> !MAIN_OSC_EN_O)
        else $error("main oscillator runs during stop");
    a_refuse_stop: assert property ((wr_proc && WDATA_I[7] && !CPU_SRC_O[1] && MAIN_OSC_EN_O && !STOP_I)
        ##1 (!wr_proc && !STOP_I) [*3] |-> MAIN_OSC_EN_O) else $error("main stopped while driving cpu");
    a_mode_bits: assert property (wr_mode ##1 !wr_mode [*2] |-> ##1
        SUB_OSC_EN_O == !$past(WDATA_I[0], 3) && FB_RES_EN_O == !$past(WDATA_I[1], 3)) else $error("mode bits lost");
    a_switch_time: assert property ((wr_sub && WDATA_I[4] && !CPU_SRC_O[1] && CPU_CLK_GATE_O) ##1 !wr_sub [*4]
        |-> ##[1:2] CPU_SRC_O[1]) else $error("subsystem clock not taken in time");
    // Gap before the status flips is what keeps runt pulses off the CPU clock
    a_status_gap: assert property ($changed(CPU_SRC_O[1]) |-> !$past(CPU_CLK_GATE_O))
        else $error("source changed without gap");
    a_gap_len: assert property ($fell(CPU_CLK_GATE_O) |-> !CPU_CLK_GATE_O [*3] ##1 CPU_CLK_GATE_O)
        else $error("switch gap length wrong");
    a_status_read: assert property (rd_sub ##1 !RD_I |-> ##1 RDATA_O[5] == $past(CPU_SRC_O[1], 2)
        && RDATA_O[7:6] == 2'h0 && RDATA_O[3:0] == 4'h0) else $error("status read wrong");
    c_to_sub: cover property (wr_sub && WDATA_I[4]);
    c_gap: cover property ($fell(CPU_CLK_GATE_O));
    c_stop_ok: cover property (wr_proc && WDATA_I[7] && CPU_SRC_O[1]);
endmodule : ccs_props

bind ccs_top ccs_props u_props (.REF_CLK_I, .RST_I, .STOP_I, .ADDR_I, .WR_I, .WDATA_I, .RD_I, .RDATA_O,
    .MAIN_OSC_EN_O, .SUB_OSC_EN_O, .FB_RES_EN_O, .CPU_SRC_O, .CPU_CLK_GATE_O);

// [bench/tb.sv]
// Testbench: register-level checks of the CPU clock selector
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    logic        REF_CLK_I = 1'b0;
    logic        RST_I     = 1'b1;
    logic        PIN_RST_I = 1'b1;
    logic        STOP_I    = 1'b0;
    logic [15:0] ADDR_I    = 16'h0000;
    logic        WR_I      = 1'b0;
    logic [7:0]  WDATA_I   = 8'h00;
    logic        RD_I      = 1'b0;
    logic [7:0]  RDATA_O;
    logic [7:0]  nm_rdata;
    logic [1:0]  nm_src;
    logic        MAIN_OSC_EN_O;
    logic        SUB_OSC_EN_O;
    logic        FB_RES_EN_O;
    logic        CPU_CLK_GATE_O;
    logic [1:0]  CPU_SRC_O;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    ccs_top dut (.REF_CLK_I, .RST_I, .PIN_RST_I, .STOP_I, .ADDR_I, .WR_I, .WDATA_I, .RD_I, .RDATA_O,
        .MAIN_OSC_EN_O, .SUB_OSC_EN_O, .FB_RES_EN_O, .CPU_SRC_O, .CPU_CLK_GATE_O);
    // Variant without the multiplier register; its read data and chosen source are watched
    ccs_top #(.HAS_MULT_REG(1'b0)) dut_nm (.REF_CLK_I, .RST_I, .PIN_RST_I, .STOP_I, .ADDR_I, .WR_I, .WDATA_I, .RD_I,
        .RDATA_O(nm_rdata), .MAIN_OSC_EN_O(), .SUB_OSC_EN_O(), .FB_RES_EN_O(), .CPU_SRC_O(nm_src),
        .CPU_CLK_GATE_O());

    // ------------------------------------------------------------
    // Clock, watchdog and access tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 REF_CLK_I = ~REF_CLK_I;
    end
    // Whole run is under a hundred cycles; the ceiling only cuts a hang
    always @(posedge REF_CLK_I) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ADDR_I = a;
        WDATA_I = d;
        WR_I = 1'b1;
        tick(1);
        // One idle edge, so a following write never re-raises the strobe in the same step
        WR_I = 1'b0;
        tick(1);
    endtask : wr
    // Read data stands until the next read, so it is sampled one cycle late
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        ADDR_I = a;
        RD_I = 1'b1;
        tick(1);
        RD_I = 1'b0;
        tick(1);
        check(RDATA_O, exp);
    endtask : rd
    task automatic wait_src(input logic [1:0] exp);
        for (int i = 0; i < 20 && CPU_SRC_O !== exp; i++) begin
            tick(1);
        end
        check({6'h00, CPU_SRC_O}, {6'h00, exp});
    endtask : wait_src
    task automatic summarize();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(4);
        RST_I = 1'b0;
        PIN_RST_I = 1'b0;
        check({5'h00, MAIN_OSC_EN_O, SUB_OSC_EN_O, FB_RES_EN_O}, 8'h07);
        rd(ADDR_PROC_CLK, RST_PROC_CLK);
        rd(ADDR_OSC_MODE, RST_OSC_MODE);
        rd(ADDR_SUB_CTRL, RST_SUB_CTRL);
        rd(ADDR_MULT_SEL, 8'h00);
        wr(16'hFF00, 8'hFF);
        rd(16'hFF00, 8'h00);
        rd(ADDR_PROC_CLK, 8'h02);
        // Stop request while main drives the CPU: stop refused, divide bit taken
        wr(ADDR_PROC_CLK, 8'h80);
        tick(3);
        check({7'h00, MAIN_OSC_EN_O}, 8'h01);
        rd(ADDR_PROC_CLK, 8'h00);
        wait_src(SRC_MAIN);
        wr(ADDR_PROC_CLK, 8'h02);
        wait_src(SRC_MAIN_DIV);
        wr(ADDR_OSC_MODE, 8'h03);
        tick(3);
        check({6'h00, SUB_OSC_EN_O, FB_RES_EN_O}, 8'h00);
        rd(ADDR_OSC_MODE, 8'h03);
        wr(ADDR_OSC_MODE, 8'h00);
        tick(3);
        check({6'h00, SUB_OSC_EN_O, FB_RES_EN_O}, 8'h03);
        STOP_I = 1'b1;
        tick(4);
        check({7'h00, MAIN_OSC_EN_O}, 8'h00);
        STOP_I = 1'b0;
        tick(4);
        check({7'h00, MAIN_OSC_EN_O}, 8'h01);
        // Multiplier bit takes only its first write of two in a row
        wr(ADDR_MULT_SEL, 8'h01);
        wr(ADDR_MULT_SEL, 8'h00);
        rd(ADDR_MULT_SEL, 8'h01);
        check(nm_rdata, 8'h00);
        wr(ADDR_SUB_CTRL, 8'h10);
        // One edge after the write the gap has opened but the old source still stands
        check({6'h00, CPU_SRC_O}, {6'h00, SRC_MAIN_DIV});
        check({7'h00, CPU_CLK_GATE_O}, 8'h00);
        wait_src(SRC_SUB_MULT);
        check({7'h00, CPU_CLK_GATE_O}, 8'h01);
        check({6'h00, nm_src}, {6'h00, SRC_SUB});
        rd(ADDR_SUB_CTRL, 8'h30);
        wr(ADDR_PROC_CLK, 8'h82);
        tick(3);
        check({7'h00, MAIN_OSC_EN_O}, 8'h00);
        rd(ADDR_PROC_CLK, 8'h82);
        // Plain reset keeps the multiplier bit, pin reset clears it
        RST_I = 1'b1;
        tick(2);
        RST_I = 1'b0;
        rd(ADDR_MULT_SEL, 8'h01);
        rd(ADDR_SUB_CTRL, 8'h00);
        RST_I = 1'b1;
        PIN_RST_I = 1'b1;
        tick(2);
        RST_I = 1'b0;
        PIN_RST_I = 1'b0;
        rd(ADDR_MULT_SEL, 8'h00);
        wr(ADDR_MULT_SEL, 8'h00);
        wr(ADDR_MULT_SEL, 8'h01);
        wr(ADDR_SUB_CTRL, 8'h10);
        wait_src(SRC_SUB);
        rd(ADDR_SUB_CTRL, 8'h30);
        summarize();
    end
endmodule : tb
